// File: aof_pkg.sv
// Constants and types shared by the output filter configuration block.
package aof_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] OUTPUT_RANGE_FILTER_CONFIG_ADDR = 8'h0E;
   localparam logic [7:0] HIGHPASS_CUTOFF_SELECT_ADDR     = 8'h0F;

   // ==========================================================
   // Field positions
   localparam int HP_OUTPUT_SELECT_BIT   = 4;
   localparam int FULL_SCALE_SELECT_HI   = 1;
   localparam int FULL_SCALE_SELECT_LO   = 0;
   localparam int TAP_HP_BYPASS_BIT      = 5;
   localparam int TAP_LP_ENABLE_BIT      = 4;
   localparam int CUTOFF_SELECT_HI       = 1;
   localparam int CUTOFF_SELECT_LO       = 0;

   // Bits that exist in each register; all others read as zero.
   localparam logic [7:0] RANGE_CFG_USED_MASK  = 8'h13;
   localparam logic [7:0] CUTOFF_CFG_USED_MASK = 8'h33;

   // ==========================================================
   // Reset values
   localparam logic [1:0] FULL_SCALE_RESET    = 2'h0;
   localparam logic       HP_OUTPUT_RESET     = 1'h0;
   localparam logic       TAP_HP_BYPASS_RESET = 1'h0;
   localparam logic       TAP_LP_ENABLE_RESET = 1'h0;
   localparam logic [1:0] CUTOFF_SELECT_RESET = 2'h0;

   // ==========================================================
   // Full-scale codes
   localparam logic [1:0] FULL_SCALE_2G       = 2'h0;
   localparam logic [1:0] FULL_SCALE_4G       = 2'h1;
   localparam logic [1:0] FULL_SCALE_8G       = 2'h2;
   localparam logic [1:0] FULL_SCALE_RESERVED = 2'h3;

   // ==========================================================
   // Output sample rate index: 800, 400, 200, 100, 50, 12.5, 6.25, 1.56 Hz.
   localparam logic [2:0] RATE_800 = 3'h0;
   localparam logic [2:0] RATE_400 = 3'h1;
   localparam logic [2:0] RATE_200 = 3'h2;
   localparam logic [2:0] RATE_100 = 3'h3;
   localparam logic [2:0] RATE_50  = 3'h4;
   localparam logic [2:0] RATE_12P5 = 3'h5;

   // Cutoff is 16 Hz divided by two to the power of this shift.
   localparam logic [3:0] SHIFT_RESET = 4'h0;

   localparam int SAMPLE_WIDTH = 14;

   typedef enum logic [1:0] {
      AOF_OS_NORMAL,
      AOF_OS_LOW_NOISE_LOW_POWER,
      AOF_OS_HIGH_RES,
      AOF_OS_LOW_POWER
   } aof_os_mode_e;

endpackage : aof_pkg

// File: aof_cutoff.sv
// High-pass corner lookup from cutoff code, sample rate and oversampling.
module aof_cutoff
(
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire aof_pkg::aof_os_mode_e os_mode_i,
   input  wire logic [2:0]           rate_i,
   input  wire logic [1:0]           cutoff_sel_i,
   output logic      [3:0]           cutoff_shift_o
);

   logic [3:0] base_shift;
   logic [3:0] next_cutoff_shift;

   // ==========================================================
   // Lookup
   // Highest corner of each row (code 0), as a halving count from 16 Hz.
   always_comb
   begin
      base_shift = 4'h0;
      unique case (os_mode_i)
         aof_pkg::AOF_OS_HIGH_RES:
         begin
            base_shift = 4'h0;
         end
         aof_pkg::AOF_OS_NORMAL, aof_pkg::AOF_OS_LOW_NOISE_LOW_POWER:
         begin
            if (rate_i <= aof_pkg::RATE_400)
               base_shift = 4'h0;
            else if (rate_i == aof_pkg::RATE_200)
               base_shift = 4'h1;
            else if (rate_i == aof_pkg::RATE_100)
               base_shift = 4'h2;
            else if (rate_i == aof_pkg::RATE_50 ||
                     os_mode_i == aof_pkg::AOF_OS_NORMAL)
               base_shift = 4'h3;
            else
               base_shift = 4'h5;
         end
         aof_pkg::AOF_OS_LOW_POWER:
         begin
            if (rate_i >= aof_pkg::RATE_12P5)
               base_shift = 4'h6;
            else
               base_shift = {1'b0, rate_i};
         end
      endcase
      next_cutoff_shift = base_shift + {2'h0, cutoff_sel_i};
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         cutoff_shift_o <= aof_pkg::SHIFT_RESET;
      else
         cutoff_shift_o <= next_cutoff_shift;
   end

endmodule : aof_cutoff

// File: aof_top.sv
// Output range, data path filter selection and tap filter configuration.

// Notes on behaviour
// RULE1 - Select bit one routes high-pass samples out.
// RULE2 - Full scale codes 2g, 4g, 8g; 11 reserved.
// RULE3 - Reset gives 2g and unfiltered output.
// RULE4 - Tap bypass bit skips high-pass for taps.
// RULE5 - Tap low-pass bit inserts low-pass for taps.
// RULE6 - Cutoff code, high resolution: 16 to 2 Hz.
// RULE7 - Normal mode corners drop with slower rates.
// RULE8 - Low-noise mode matches normal, slower below 50.
// RULE9 - Low-power corners halve per rate down to 50 Hz and per code; 12.5 Hz and slower share one row.
// RULE10 - Fixed zero bits read zero, ignore writes.
module aof_top
(
   input  wire logic                              CORE_CLK_I,
   input  wire logic                              RST_N_I,
   input  wire logic [7:0]                        REG_ADDR_I,
   input  wire logic                              REG_WR_I,
   input  wire logic [7:0]                        REG_WDATA_I,
   input  wire logic                              REG_RD_I,
   output logic      [7:0]                        REG_RDATA_O,
   output logic                                   REG_RVALID_O,
   input  wire logic [2:0]                        RATE_I,
   input  wire aof_pkg::aof_os_mode_e             OS_MODE_I,
   input  wire logic                              SAMPLE_VALID_I,
   input  wire logic [aof_pkg::SAMPLE_WIDTH-1:0]  RAW_SAMPLE_I,
   input  wire logic [aof_pkg::SAMPLE_WIDTH-1:0]  HP_SAMPLE_I,
   output logic                                   OUT_VALID_O,
   output logic      [aof_pkg::SAMPLE_WIDTH-1:0]  OUT_SAMPLE_O,
   output logic      [1:0]                        FULL_SCALE_O,
   output logic                                   HP_OUTPUT_SELECT_O,
   output logic                                   TAP_HP_BYPASS_O,
   output logic                                   TAP_LP_ENABLE_O,
   output logic      [3:0]                        CUTOFF_SHIFT_O
);

   // Register image with fixed-zero bits forced low.
   function automatic logic [7:0] range_image(input logic       hp,
                                              input logic [1:0] fs);
      logic [7:0] img;
      img = 8'h00;
      img[aof_pkg::HP_OUTPUT_SELECT_BIT] = hp;
      img[aof_pkg::FULL_SCALE_SELECT_HI] = fs[1];
      img[aof_pkg::FULL_SCALE_SELECT_LO] = fs[0];
      return img & aof_pkg::RANGE_CFG_USED_MASK;
   endfunction : range_image

   function automatic logic [7:0] cutoff_image(input logic       byp,
                                               input logic       lpe,
                                               input logic [1:0] sel);
      logic [7:0] img;
      img = 8'h00;
      img[aof_pkg::TAP_HP_BYPASS_BIT] = byp;
      img[aof_pkg::TAP_LP_ENABLE_BIT] = lpe;
      img[aof_pkg::CUTOFF_SELECT_HI]  = sel[1];
      img[aof_pkg::CUTOFF_SELECT_LO]  = sel[0];
      return img & aof_pkg::CUTOFF_CFG_USED_MASK;
   endfunction : cutoff_image

   logic       write_range;
   logic       write_cutoff;
   logic [1:0] cutoff_sel;
   logic [1:0] next_full_scale;
   logic       next_hp_select;
   logic       next_tap_bypass;
   logic       next_tap_lp;
   logic [1:0] next_cutoff_sel;
   logic [7:0] next_rdata;
   logic       next_rvalid;
   logic       next_out_valid;
   logic [aof_pkg::SAMPLE_WIDTH-1:0] next_out_sample;
   logic [1:0] wr_fs;

   // ==========================================================
   // Configuration registers
   always_comb
   begin
      write_range  = REG_WR_I &&
                     REG_ADDR_I == aof_pkg::OUTPUT_RANGE_FILTER_CONFIG_ADDR;
      write_cutoff = REG_WR_I &&
                     REG_ADDR_I == aof_pkg::HIGHPASS_CUTOFF_SELECT_ADDR;
      wr_fs = {REG_WDATA_I[aof_pkg::FULL_SCALE_SELECT_HI],
               REG_WDATA_I[aof_pkg::FULL_SCALE_SELECT_LO]};
      next_full_scale = FULL_SCALE_O;
      next_hp_select  = HP_OUTPUT_SELECT_O;
      next_tap_bypass = TAP_HP_BYPASS_O;
      next_tap_lp     = TAP_LP_ENABLE_O;
      next_cutoff_sel = cutoff_sel;
      if (write_range)
      begin
         next_hp_select = REG_WDATA_I[aof_pkg::HP_OUTPUT_SELECT_BIT];
         // The reserved code is refused; the last valid range stays.
         if (wr_fs != aof_pkg::FULL_SCALE_RESERVED) // [RULE2]
            next_full_scale = wr_fs;
      end
      if (write_cutoff)
      begin
         next_tap_bypass = REG_WDATA_I[aof_pkg::TAP_HP_BYPASS_BIT]; // [RULE4]
         next_tap_lp     = REG_WDATA_I[aof_pkg::TAP_LP_ENABLE_BIT]; // [RULE5]
         next_cutoff_sel = {REG_WDATA_I[aof_pkg::CUTOFF_SELECT_HI],
                            REG_WDATA_I[aof_pkg::CUTOFF_SELECT_LO]};
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_N_I)
      begin
         FULL_SCALE_O       <= aof_pkg::FULL_SCALE_RESET;    // [RULE3]
         HP_OUTPUT_SELECT_O <= aof_pkg::HP_OUTPUT_RESET;     // [RULE3]
         TAP_HP_BYPASS_O    <= aof_pkg::TAP_HP_BYPASS_RESET; // [RULE4]
         TAP_LP_ENABLE_O    <= aof_pkg::TAP_LP_ENABLE_RESET; // [RULE5]
         cutoff_sel         <= aof_pkg::CUTOFF_SELECT_RESET; // [RULE6]
      end
      else
      begin
         FULL_SCALE_O       <= next_full_scale;
         HP_OUTPUT_SELECT_O <= next_hp_select;
         TAP_HP_BYPASS_O    <= next_tap_bypass;
         TAP_LP_ENABLE_O    <= next_tap_lp;
         cutoff_sel         <= next_cutoff_sel;
      end
   end

   // ==========================================================
   // Register read port
   always_comb
   begin
      next_rvalid = REG_RD_I;
      next_rdata  = 8'h00;
      if (REG_RD_I)
      begin
         unique case (REG_ADDR_I)
            aof_pkg::OUTPUT_RANGE_FILTER_CONFIG_ADDR:
            begin
               next_rdata = range_image(HP_OUTPUT_SELECT_O,
                                        FULL_SCALE_O); // [RULE10]
            end
            aof_pkg::HIGHPASS_CUTOFF_SELECT_ADDR:
            begin
               next_rdata = cutoff_image(TAP_HP_BYPASS_O, TAP_LP_ENABLE_O,
                                         cutoff_sel); // [RULE10]
            end
            default:
            begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_N_I)
      begin
         REG_RDATA_O  <= 8'h00;
         REG_RVALID_O <= 1'b0;
      end
      else
      begin
         REG_RDATA_O  <= next_rdata;
         REG_RVALID_O <= next_rvalid;
      end
   end

   // ==========================================================
   // Output data path selection
   always_comb
   begin
      next_out_valid  = SAMPLE_VALID_I;
      next_out_sample = OUT_SAMPLE_O;
      if (SAMPLE_VALID_I)
         next_out_sample = HP_OUTPUT_SELECT_O ? HP_SAMPLE_I
                                              : RAW_SAMPLE_I; // [RULE1]
   end

   always_ff @(posedge CORE_CLK_I)
   begin
      if (!RST_N_I)
      begin
         OUT_VALID_O  <= 1'b0;
         OUT_SAMPLE_O <= '0;
      end
      else
      begin
         OUT_VALID_O  <= next_out_valid;
         OUT_SAMPLE_O <= next_out_sample;
      end
   end

   // ==========================================================
   // Cutoff lookup
   aof_cutoff u_cutoff
   (
      .clk_i          (CORE_CLK_I),
      .rst_n_i        (RST_N_I),
      .os_mode_i      (OS_MODE_I),
      .rate_i         (RATE_I),
      .cutoff_sel_i   (cutoff_sel),
      .cutoff_shift_o (CUTOFF_SHIFT_O) // [RULE6] [RULE7] [RULE8] [RULE9]
   );

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RST_N_I);

   AST_OUT_HP: assert property ( // [RULE1]
      SAMPLE_VALID_I && HP_OUTPUT_SELECT_O
      |=> OUT_VALID_O && OUT_SAMPLE_O == $past(HP_SAMPLE_I))
      else $error("High-pass sample not delivered.");

   AST_OUT_RAW: assert property ( // [RULE1]
      SAMPLE_VALID_I && !HP_OUTPUT_SELECT_O
      |=> OUT_VALID_O && OUT_SAMPLE_O == $past(RAW_SAMPLE_I))
      else $error("Raw sample not delivered.");

   AST_FS_RESERVED: assert property ( // [RULE2]
      write_range && wr_fs == aof_pkg::FULL_SCALE_RESERVED
      |=> FULL_SCALE_O == $past(FULL_SCALE_O)
          && FULL_SCALE_O != aof_pkg::FULL_SCALE_RESERVED)
      else $error("Reserved full scale accepted.");

   AST_RESET_STATE: assert property ( // [RULE3]
      $rose(RST_N_I)
      |-> FULL_SCALE_O == aof_pkg::FULL_SCALE_2G && !HP_OUTPUT_SELECT_O
          && !TAP_HP_BYPASS_O && !TAP_LP_ENABLE_O)
      else $error("Wrong state after reset.");

   AST_TAP_BYPASS: assert property ( // [RULE4]
      write_cutoff
      |=> TAP_HP_BYPASS_O == $past(REG_WDATA_I[aof_pkg::TAP_HP_BYPASS_BIT]))
      else $error("Tap bypass not updated.");

   AST_TAP_LOWPASS: assert property ( // [RULE5]
      write_cutoff ##1 !write_cutoff[*2]
      |-> TAP_LP_ENABLE_O
          == $past(REG_WDATA_I[aof_pkg::TAP_LP_ENABLE_BIT], 2))
      else $error("Tap low-pass enable not held.");

   AST_CUT_HIGHRES: assert property ( // [RULE6]
      OS_MODE_I == aof_pkg::AOF_OS_HIGH_RES
      |=> CUTOFF_SHIFT_O == {2'h0, $past(cutoff_sel)})
      else $error("High resolution corner wrong.");

   AST_CUT_NORMAL: assert property ( // [RULE7]
      OS_MODE_I == aof_pkg::AOF_OS_NORMAL && RATE_I >= aof_pkg::RATE_50
      |=> CUTOFF_SHIFT_O == 4'h3 + {2'h0, $past(cutoff_sel)})
      else $error("Normal mode slow corner wrong.");

   AST_CUT_LOWNOISE: assert property ( // [RULE8]
      OS_MODE_I == aof_pkg::AOF_OS_LOW_NOISE_LOW_POWER
      && RATE_I >= aof_pkg::RATE_12P5
      |=> CUTOFF_SHIFT_O == 4'h5 + {2'h0, $past(cutoff_sel)})
      else $error("Low-noise slow corner wrong.");

   AST_CUT_LOWPOWER: assert property ( // [RULE9]
      OS_MODE_I == aof_pkg::AOF_OS_LOW_POWER && RATE_I == aof_pkg::RATE_100
      |=> CUTOFF_SHIFT_O == 4'h3 + {2'h0, $past(cutoff_sel)})
      else $error("Low-power corner wrong.");

   AST_READ_ZERO: assert property ( // [RULE10]
      REG_RD_I |=> REG_RVALID_O
      && (REG_RDATA_O
          & ~(($past(REG_ADDR_I) == aof_pkg::OUTPUT_RANGE_FILTER_CONFIG_ADDR)
              ? aof_pkg::RANGE_CFG_USED_MASK
              : ($past(REG_ADDR_I) == aof_pkg::HIGHPASS_CUTOFF_SELECT_ADDR)
              ? aof_pkg::CUTOFF_CFG_USED_MASK : 8'h00)) == 8'h00)
      else $error("Fixed-zero bits read non-zero.");

   AST_HP_SELECT_WR: assert property ( // [RULE1]
      write_range
      |=> HP_OUTPUT_SELECT_O
          == $past(REG_WDATA_I[aof_pkg::HP_OUTPUT_SELECT_BIT]))
      else $error("Output select bit not updated.");

   AST_OUT_IDLE: assert property ( // [RULE1]
      !SAMPLE_VALID_I |=> !OUT_VALID_O && $stable(OUT_SAMPLE_O))
      else $error("Output changed without a new sample.");

   AST_FS_WRITE: assert property ( // [RULE2]
      write_range && wr_fs != aof_pkg::FULL_SCALE_RESERVED
      |=> FULL_SCALE_O == $past(wr_fs))
      else $error("Valid full scale not accepted.");

   AST_RESET_CUTOFF: assert property ( // [RULE6]
      $rose(RST_N_I)
      |-> cutoff_sel == aof_pkg::CUTOFF_SELECT_RESET
          && CUTOFF_SHIFT_O == aof_pkg::SHIFT_RESET)
      else $error("Cutoff select not cleared by reset.");

   AST_CUT_SEL_WRITE: assert property ( // [RULE6]
      write_cutoff
      |=> cutoff_sel == $past({REG_WDATA_I[aof_pkg::CUTOFF_SELECT_HI],
                                REG_WDATA_I[aof_pkg::CUTOFF_SELECT_LO]}))
      else $error("Cutoff select not updated.");

   AST_CUT_FAST: assert property ( // [RULE7]
      (OS_MODE_I == aof_pkg::AOF_OS_NORMAL
       || OS_MODE_I == aof_pkg::AOF_OS_LOW_NOISE_LOW_POWER)
      && RATE_I <= aof_pkg::RATE_400
      |=> CUTOFF_SHIFT_O == {2'h0, $past(cutoff_sel)})
      else $error("Fast rate corner wrong.");

   AST_CUT_MID: assert property ( // [RULE7]
      OS_MODE_I == aof_pkg::AOF_OS_NORMAL && RATE_I == aof_pkg::RATE_100
      |=> CUTOFF_SHIFT_O == 4'h2 + {2'h0, $past(cutoff_sel)})
      else $error("Normal mode mid corner wrong.");

   AST_CUT_LOWNOISE_50: assert property ( // [RULE8]
      OS_MODE_I == aof_pkg::AOF_OS_LOW_NOISE_LOW_POWER
      && RATE_I == aof_pkg::RATE_50
      |=> CUTOFF_SHIFT_O == 4'h3 + {2'h0, $past(cutoff_sel)})
      else $error("Low-noise corner at the middle rate wrong.");

   AST_CUT_LOWPOWER_SLOW: assert property ( // [RULE9]
      OS_MODE_I == aof_pkg::AOF_OS_LOW_POWER
      && RATE_I >= aof_pkg::RATE_12P5
      |=> CUTOFF_SHIFT_O == 4'h6 + {2'h0, $past(cutoff_sel)})
      else $error("Low-power slow corner wrong.");

   AST_READ_IDLE: assert property ( // [RULE10]
      !REG_RD_I |=> !REG_RVALID_O && REG_RDATA_O == 8'h00)
      else $error("Read answer without a read.");

endmodule : aof_top

// File: aof_host.sv
// Host model that reaches the configuration registers over the strobe port.
module aof_host
(
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   input  wire logic       rvalid_i,
   output logic      [7:0] addr_o,
   output logic            wr_o,
   output logic      [7:0] wdata_o,
   output logic            rd_o
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      wdata_o = 8'h00;
      rd_o = 1'b0;
   end

   // ==========================================================
   // Bus cycles, each strobe held for exactly one rising edge
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      wdata_o = ~d;
   endtask : write_reg

   task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                           output logic ok);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      ok = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 3 && !ok; i++)
      begin
         if (rvalid_i === 1'b1)
         begin
            ok = 1'b1;
            d = rdata_i;
         end
         else
            @(negedge clk_i);
      end
   endtask : read_reg
endmodule : aof_host

// File: accel_output_filter_config_test.sv
// Self-checking testbench of the output filter configuration block.
module accel_output_filter_config_test;
   timeunit 1ns;
   timeprecision 1ns;

   logic                  clk;
   logic                  rst_n;
   logic [7:0]            addr;
   logic                  wr;
   logic [7:0]            wdata;
   logic                  rd;
   logic [7:0]            rdata;
   logic                  rvalid;
   logic [2:0]            rate;
   aof_pkg::aof_os_mode_e os_mode;
   logic                  sv;
   logic [13:0]           raw;
   logic [13:0]           hp;
   logic                  out_valid;
   logic [13:0]           out_sample;
   logic [1:0]            fs_o;
   logic                  hpo_o;
   logic                  byp_o;
   logic                  lpe_o;
   logic [3:0]            shift_o;
   int                    errors = 0;
   int                    checks = 0;
   int                    fs, hpo, byp, lpe, sel;

   aof_top u_aof_top (.CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
      .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
      .REG_RVALID_O(rvalid), .RATE_I(rate), .OS_MODE_I(os_mode),
      .SAMPLE_VALID_I(sv), .RAW_SAMPLE_I(raw), .HP_SAMPLE_I(hp),
      .OUT_VALID_O(out_valid), .OUT_SAMPLE_O(out_sample),
      .FULL_SCALE_O(fs_o), .HP_OUTPUT_SELECT_O(hpo_o),
      .TAP_HP_BYPASS_O(byp_o), .TAP_LP_ENABLE_O(lpe_o),
      .CUTOFF_SHIFT_O(shift_o));

   aof_host u_aof_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
      .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));

   initial clk = 1'b0;
   always #20 clk = ~clk;

   // ==========================================================
   // Reference model and comparison helpers
   function automatic int exp_shift(int m, int r, int s);
      int b;
      b = r;
      if (m == 2)
         b = 0;
      else if (m == 3)
         b = (r > 4) ? 6 : r;
      else
      begin
         b = (r < 2) ? 0 : ((r > 4) ? 3 : r - 1);
         if (m == 1 && r > 4)
            b = 5;
      end
      return b + s;
   endfunction : exp_shift

   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic conclude();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude

   // Reads one register and compares it with the model image.
   task automatic read_check(logic [7:0] a);
      logic [7:0] d;
      logic       ok;
      int         e;
      e = 0;
      if (a == 8'h0E)
         e = hpo * 16 + fs;
      if (a == 8'h0F)
         e = byp * 32 + lpe * 16 + sel;
      u_aof_host.read_reg(a, d, ok);
      check("read_valid", 16'h0001, 16'(ok));
      check("read_data", 16'(e), 16'(d));
   endtask : read_check

   task automatic wr_check(logic [7:0] a, logic [7:0] d);
      u_aof_host.write_reg(a, d);
      if (a == 8'h0E)
      begin
         hpo = d[4];
         if (d[1:0] != 2'h3)
            fs = d[1:0];
      end
      if (a == 8'h0F)
      begin
         byp = d[5];
         lpe = d[4];
         sel = d[1:0];
      end
      repeat (3) @(negedge clk);
      check("full_scale", 16'(fs), 16'(fs_o));
      check("hp_select", 16'(hpo), 16'(hpo_o));
      check("tap_bypass", 16'(byp), 16'(byp_o));
      check("tap_lowpass", 16'(lpe), 16'(lpe_o));
      read_check(a);
   endtask : wr_check

   task automatic reset_check();
      fs = 0;
      hpo = 0;
      byp = 0;
      lpe = 0;
      sel = 0;
      check("reset_fs", 16'h0000, 16'(fs_o));
      check("reset_hpo", 16'h0000, 16'(hpo_o));
      check("reset_shift", 16'h0000, 16'(shift_o));
      check("reset_byp", 16'h0000, 16'(byp_o));
      check("reset_lpe", 16'h0000, 16'(lpe_o));
      read_check(8'h0E);
      read_check(8'h0F);
      read_check(8'h10);
   endtask : reset_check

   // Random sample stream; expected outputs wait in a queue until delivered.
   task automatic burst();
      int          q[$];
      logic        pv;
      logic [13:0] pexp;
      pv = 1'b0;
      for (int i = 0; i < 24; i++)
      begin
         @(negedge clk);
         check("out_valid", 16'(pv), 16'(out_valid));
         if (pv)
         begin
            pexp = 14'(q.pop_front());
            check("out_sample", 16'(pexp), 16'(out_sample));
         end
         pv = (i < 22) && ($urandom_range(0, 3) != 0);
         raw = 14'($urandom);
         hp = 14'($urandom);
         sv = pv;
         if (pv)
            q.push_back((hpo != 0) ? int'(hp) : int'(raw));
      end
      check("queue_left", 16'h0000, 16'(q.size()));
   endtask : burst

   // Compares the corner shift with the reference for one setting.
   task automatic shift_check(int m, int r, int s);
      logic [15:0] e;
      e = 16'(exp_shift(m, r, s));
      check("shift", e, 16'(shift_o));
   endtask : shift_check

   // ==========================================================
   // Main sequence
   initial
   begin
      void'($urandom(62525));
      rst_n = 1'b0;
      rate = 3'h0;
      os_mode = aof_pkg::AOF_OS_NORMAL;
      sv = 1'b0;
      raw = 14'h0000;
      hp = 14'h0000;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      reset_check();
      for (int i = 0; i < 16; i++)
         wr_check(8'h0E, {6'($urandom), 2'(i)});
      for (int i = 0; i < 12; i++)
         wr_check(8'h0F, 8'($urandom));
      u_aof_host.write_reg(8'h10, 8'hFF);
      read_check(8'h10);
      read_check(8'h0E);
      read_check(8'h0F);
      for (int m = 0; m < 4; m++)
         for (int r = 0; r < 8; r++)
            for (int s = 0; s < 4; s++)
            begin
               os_mode = aof_pkg::aof_os_mode_e'(m);
               rate = 3'(r);
               wr_check(8'h0F, {6'($urandom), 2'(s)});
               shift_check(m, r, s);
            end
      wr_check(8'h0E, 8'h00);
      burst();
      wr_check(8'h0E, 8'h12);
      burst();
      wr_check(8'h0F, 8'h33);
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      reset_check();
      conclude();
   end

   initial
   begin
      #(40 * 8000);
      errors++;
      conclude();
   end
endmodule : accel_output_filter_config_test
